// *** hw/sync_buf_defines.svh ***
`ifndef SYNC_BUF_DEFINES_SVH
`define SYNC_BUF_DEFINES_SVH
`define STYPE_A          8'h06
`define STYPE_B          8'h14
`define ENCAP_A          8'h02
`define ENCAP_B          8'h05
`define ENCAP_C          8'h07
`define ENCAP_D          8'h09
`define DL_TABLE_ID      8'h3C
`define DDB_SKIP_BYTES   8'h06
`define SEC_HDR_BYTES    8'h08
`define SEC_CRC_BYTES    8'h04
`define TRANSPORT_BYTES  512
`define DEB_MIN_BYTES    120120
`define NOMINAL_AU_BYTES 40040
`define AU_SPACING_NS    5561111
`define CLK_PERIOD_NS    8
`define AU_SPACING_CYC   ((`AU_SPACING_NS) / (`CLK_PERIOD_NS))
`define LEAK_LOW_KBPS    384
`define LEAK_MID_KBPS    3840
`define LEAK_HIGH_KBPS   19200
`define SMOOTHING_SIZE_LOW      4500
`define SMOOTHING_SIZE_HIGH     10000
`define CLK_KHZ          125000
`endif

// *** hw/sync_buf_pkg.sv ***
package sync_buf_pkg;
  typedef enum logic [1:0] {
    carriage_pes,
    carriage_section,
    carriage_none
  } carriage_e;
  typedef enum logic [1:0] {
    profile_lowest,
    profile_mid,
    profile_high
  } profile_e;
  typedef enum {
    st_idle,
    st_hdr,
    st_pay,
    st_crc
  } parse_e;
endpackage : sync_buf_pkg

// *** hw/sync_fifo.sv ***
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sync_fifo

// *** hw/synced_data_decoder_buffer.sv ***
`timescale 1ns/1ps
`include "sync_buf_defines.svh"
module synced_data_decoder_buffer
  import sync_buf_pkg::*;
#(
  parameter int DEB_BYTES = `DEB_MIN_BYTES,
  parameter int MAX_UNITS = 4,
  parameter int AU_GAP    = `AU_SPACING_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Stream configuration
  input  wire logic [7:0]  stream_type,
  input  wire logic [7:0]  encap_code,
  input  wire logic        streaming,
  input  wire logic [1:0]  profile,
  input  wire logic        sb_desc_present,
  input  wire logic [31:0] smoothing_leak_rate,
  input  wire logic        delay_valid,
  input  wire logic [32:0] delay_ticks,
  // Reference time, 90 kHz units
  input  wire logic [32:0] stc_now,
  // Demultiplexed payload bytes
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_dup,
  input  wire logic        in_pes_start,
  input  wire logic        in_sec_start,
  input  wire logic        in_is_section,
  input  wire logic        in_hdr,
  input  wire logic        in_pts_valid,
  input  wire logic [32:0] in_pts,
  input  wire logic [7:0]  in_sec_num,
  input  wire logic [7:0]  in_table_id,
  input  wire logic        in_last,
  // Released unit bytes
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [7:0]       out_data,
  output logic             out_unit_end,
  // Status
  output logic             overflow_ff,
  output logic             underflow_ff
);
  localparam int DAW = $clog2(DEB_BYTES);
  localparam int UW  = $clog2(MAX_UNITS);

  logic [7:0]     deb_mem [DEB_BYTES];
  logic [DAW-1:0] deb_wr_ff;
  logic [DAW-1:0] deb_rd_ff;
  logic [DAW:0]   deb_cnt_ff;
  logic [32:0]    au_pts [MAX_UNITS];
  logic [DAW:0]   au_len [MAX_UNITS];
  logic           au_done [MAX_UNITS];
  logic [UW-1:0]  au_wr_ff;
  logic [UW-1:0]  au_rd_ff;
  logic [UW:0]    au_cnt_ff;
  logic [DAW:0]   cur_len_ff;
  logic [32:0]    prev_pts_ff;
  logic           release_ff;
  logic [DAW:0]   rel_left_ff;
  logic [31:0]    leak_acc_ff;
  logic [31:0]    gap_ff;
  logic [7:0]     skip_ff;
  logic           out_valid_ff;
  logic [7:0]     out_data_ff;
  logic           out_end_ff;
  logic           in_ready_ff;

  function automatic logic stream_ok(input logic [7:0] st, input logic [7:0] ec);
    stream_ok = (st == `STYPE_A || st == `STYPE_B) &&
                (ec == `ENCAP_A || ec == `ENCAP_B || ec == `ENCAP_C || ec == `ENCAP_D);
  endfunction : stream_ok

  function automatic logic [32:0] minus(input logic [32:0] a, input logic [32:0] b);
    minus = a - b;
  endfunction : minus

  // Wrap-safe time compare: true once now has reached t
  function automatic logic reached(input logic [32:0] now, input logic [32:0] t);
    logic [32:0] d;
    d       = now - t;
    reached = !d[32];
  endfunction : reached

  // Smoothing buffer: 32 entries of byte, header flag, unit start, last flag, section flag, stamp
  logic        sb_in_valid;
  logic        sb_in_ready;
  logic [44:0] sb_in_data;
  logic        sb_out_valid;
  logic        sb_out_ready;
  logic [44:0] sb_out_data;
  logic [5:0]  sb_cnt_ff;
  logic [5:0]  nxt_sb_cnt;

  // Stamp rides with its byte so a later stamp cannot overtake it
  assign sb_in_valid = in_valid && !in_dup && stream_ok(stream_type, encap_code);
  assign sb_in_data  = {in_pts,
                        in_is_section, in_last, (in_pes_start && in_pts_valid) ||
                        (in_sec_start && in_sec_num == 8'h00 && in_pts_valid),
                        in_hdr || (in_is_section && in_table_id != `DL_TABLE_ID),
                        in_data};
  assign in_ready    = in_ready_ff;

  // Local fill count so the registered ready never promises a slot that is gone
  assign nxt_sb_cnt = sb_cnt_ff + 6'(sb_in_valid && in_ready_ff) -
                      6'(sb_out_valid && sb_out_ready);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sb_cnt_ff   <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      sb_cnt_ff   <= nxt_sb_cnt;
      in_ready_ff <= (nxt_sb_cnt < 6'h20);
    end
  end

  sync_fifo #(.WIDTH(45), .DEPTH(32)) u_smoothing_buffer (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (sb_in_valid && in_ready_ff),
    .in_ready  (sb_in_ready),
    .in_data   (sb_in_data),
    .out_valid (sb_out_valid),
    .out_ready (sb_out_ready),
    .out_data  (sb_out_data)
  );

  // Leak rate: descriptor value or profile default, in kbit/s
  logic [31:0] leak_kbps;
  always_comb begin
    if (sb_desc_present) begin
      leak_kbps = smoothing_leak_rate;
    end else begin
      case (profile_e'(profile))
        profile_lowest: leak_kbps = 32'(`LEAK_LOW_KBPS);
        profile_mid:    leak_kbps = 32'(`LEAK_MID_KBPS);
        default:        leak_kbps = 32'(`LEAK_HIGH_KBPS);
      endcase
    end
  end

  // Credit accumulator: one byte per 8*CLK_KHZ of credit
  logic leak_tick;
  assign leak_tick    = (leak_acc_ff >= 32'(8 * `CLK_KHZ));
  logic deb_full;
  assign deb_full     = (deb_cnt_ff >= (DAW+1)'(DEB_BYTES)) || (au_cnt_ff == (UW+1)'(MAX_UNITS));
  assign sb_out_ready = leak_tick && !deb_full;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      leak_acc_ff <= '0;
    end else if (sb_out_valid && sb_out_ready) begin
      leak_acc_ff <= leak_acc_ff - 32'(8 * `CLK_KHZ) + leak_kbps;
    end else if (!leak_tick) begin
      leak_acc_ff <= leak_acc_ff + leak_kbps;
    end
  end

  // Drain from smoothing buffer into elementary buffer
  logic pop_sb;
  logic unit_start;
  logic is_hdr;
  logic is_sec;
  logic is_last;
  logic keep_byte;
  assign pop_sb     = sb_out_valid && sb_out_ready;
  assign is_sec     = sb_out_data[11];
  assign is_last    = sb_out_data[10];
  assign unit_start = sb_out_data[9];
  assign is_hdr     = sb_out_data[8];

  // Section trailer: last four bytes are CRC; skip counter eats block-header bytes
  logic [1:0] crc_hold_ff;
  assign keep_byte = pop_sb && !is_hdr && (skip_ff == 8'h00) &&
                     !(is_sec && is_last);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      skip_ff <= '0;
    end else if (pop_sb && is_sec && is_hdr && is_last) begin
      skip_ff <= `DDB_SKIP_BYTES;
    end else if (pop_sb && !is_hdr && skip_ff != 8'h00) begin
      skip_ff <= skip_ff - 8'h01;
    end
  end

  // Upstream marks header, download header and CRC bytes; in_last marks CRC
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      crc_hold_ff <= '0;
    end else if (pop_sb && is_sec && is_last) begin
      crc_hold_ff <= crc_hold_ff + 2'b01;
    end
  end

  always_ff @(posedge clock) begin
    if (keep_byte) begin
      deb_mem[deb_wr_ff] <= sb_out_data[7:0];
    end
  end

  // Unit bookkeeping
  logic close_unit;
  logic do_release;
  logic head_ready;
  logic [32:0] head_pts;
  assign close_unit = pop_sb && unit_start && (cur_len_ff != '0);
  assign head_pts   = au_pts[au_rd_ff];

  always_comb begin
    head_ready = 1'b0;
    if (au_cnt_ff != '0 && au_done[au_rd_ff] && !release_ff && gap_ff == '0) begin
      if (streaming) begin
        head_ready = reached(stc_now, prev_pts_ff);
      end else if (delay_valid) begin
        head_ready = reached(stc_now, minus(head_pts, delay_ticks));
      end else begin
        head_ready = 1'b1;
      end
    end
  end
  assign do_release = head_ready;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      deb_wr_ff  <= '0;
      cur_len_ff <= '0;
      au_wr_ff   <= '0;
      au_cnt_ff  <= '0;
      for (int i = 0; i < MAX_UNITS; i++) begin
        au_done[i] <= 1'b0;
        au_pts[i]  <= '0;
        au_len[i]  <= '0;
      end
    end else begin
      if (keep_byte) begin
        deb_wr_ff <= (deb_wr_ff == DAW'(DEB_BYTES-1)) ? '0 : deb_wr_ff + 1'b1;
      end
      if (close_unit) begin
        au_done[au_wr_ff] <= 1'b1;
        au_len[au_wr_ff]  <= cur_len_ff;
        au_wr_ff          <= au_wr_ff + 1'b1;
        cur_len_ff        <= (DAW+1)'(keep_byte);
      end else if (keep_byte) begin
        cur_len_ff <= cur_len_ff + 1'b1;
      end
      if (pop_sb && unit_start) begin
        au_pts[close_unit ? au_wr_ff + 1'b1 : au_wr_ff] <= sb_out_data[44:12];
        au_done[close_unit ? au_wr_ff + 1'b1 : au_wr_ff] <= 1'b0;
      end
      if (do_release) begin
        au_done[au_rd_ff] <= 1'b0;
      end
      au_cnt_ff <= au_cnt_ff + (UW+1)'(close_unit) - (UW+1)'(do_release);
    end
  end

  // Output: release whole unit at full clock rate
  logic pop_deb;
  assign pop_deb = release_ff && (!out_valid_ff || out_ready);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      release_ff  <= 1'b0;
      rel_left_ff <= '0;
      au_rd_ff    <= '0;
      prev_pts_ff <= '0;
      gap_ff      <= '0;
    end else begin
      if (gap_ff != '0) begin
        gap_ff <= gap_ff - 32'd1;
      end
      if (do_release) begin
        release_ff  <= (au_len[au_rd_ff] != '0);
        rel_left_ff <= au_len[au_rd_ff];
        prev_pts_ff <= head_pts;
        au_rd_ff    <= au_rd_ff + 1'b1;
        gap_ff      <= 32'(AU_GAP);
      end else if (pop_deb) begin
        rel_left_ff <= rel_left_ff - 1'b1;
        release_ff  <= (rel_left_ff != (DAW+1)'(1));
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      deb_rd_ff  <= '0;
      deb_cnt_ff <= '0;
    end else begin
      if (pop_deb) begin
        deb_rd_ff <= (deb_rd_ff == DAW'(DEB_BYTES-1)) ? '0 : deb_rd_ff + 1'b1;
      end
      deb_cnt_ff <= deb_cnt_ff + (DAW+1)'(keep_byte) - (DAW+1)'(pop_deb);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
      out_end_ff   <= 1'b0;
    end else if (pop_deb) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= deb_mem[deb_rd_ff];
      out_end_ff   <= (rel_left_ff == (DAW+1)'(1));
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
      out_end_ff   <= 1'b0;
    end
  end
  assign out_valid    = out_valid_ff;
  assign out_data     = out_data_ff;
  assign out_unit_end = out_end_ff;

  // Sticky errors; cleared only by reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_ff  <= 1'b0;
      underflow_ff <= 1'b0;
    end else begin
      if (pop_sb && !keep_byte && deb_full) begin
        overflow_ff <= 1'b1;
      end
      // Removal time exists only with a signalled delay; head is the open unit
      if (au_cnt_ff == '0 && !streaming && delay_valid && cur_len_ff != '0 &&
          reached(stc_now, minus(au_pts[au_rd_ff], delay_ticks))) begin
        underflow_ff <= 1'b1;
      end
    end
  end
endmodule : synced_data_decoder_buffer

// *** verification/stream_source.sv ***
`timescale 1ns/1ps
module stream_source (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_b,
  // Byte records toward the buffer
  output logic        in_valid,
  input  wire logic   in_ready,
  output logic [63:0] in_rec
);
  logic [63:0] pend_q[$];
  // A record stands until taken, so nothing is lost to a full buffer
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_valid <= 1'b0;
      in_rec   <= 64'h0;
    end else begin
      if (in_valid && in_ready) begin
        void'(pend_q.pop_front());
      end
      if (pend_q.size() > 0) begin
        in_valid <= 1'b1;
        in_rec   <= pend_q[0];
      end else begin
        in_valid <= 1'b0;
        in_rec   <= ~in_rec;
      end
    end
  end
endmodule : stream_source

// *** verification/synced_data_decoder_buffer_sva.sv ***
`timescale 1ns/1ps
module synced_data_decoder_buffer_sva (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // Observed ports
  input wire logic       in_ready,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [7:0] out_data,
  input wire logic       out_unit_end,
  input wire logic       overflow_ff,
  input wire logic       underflow_ff
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  sequence s_wake;
    $rose(rst_b);
  endsequence
  reset_clean_a: assert property (s_wake |-> !out_valid && !out_unit_end)
    else $error("output busy right after reset");
  flags_clear_a: assert property (s_wake |-> !overflow_ff && !underflow_ff)
    else $error("error flag set right after reset");
  ready_up_a: assert property (s_wake |=> in_ready)
    else $error("input not ready after reset");
  quiet_start_a: assert property (s_wake |-> !out_valid [*3])
    else $error("unit released before any could be complete");
  hold_data_a: assert property (s_stall |=> out_valid && $stable(out_data))
    else $error("output byte dropped while stalled");
  hold_end_a: assert property (s_stall |=> $stable(out_unit_end))
    else $error("unit end moved while stalled");
  end_valid_a: assert property (out_unit_end |-> out_valid)
    else $error("unit end without a byte");
  ovf_sticky_a: assert property (overflow_ff |=> overflow_ff)
    else $error("overflow flag cleared");
  udf_sticky_a: assert property (underflow_ff |=> underflow_ff)
    else $error("underflow flag cleared");
endmodule : synced_data_decoder_buffer_sva

bind synced_data_decoder_buffer synced_data_decoder_buffer_sva i_synced_data_decoder_buffer_sva (
  .clock       (clock),
  .rst_b       (rst_b),
  .in_ready    (in_ready),
  .out_valid   (out_valid),
  .out_ready   (out_ready),
  .out_data    (out_data),
  .out_unit_end(out_unit_end),
  .overflow_ff (overflow_ff),
  .underflow_ff(underflow_ff)
);

// *** verification/synced_data_decoder_buffer_tb.sv ***
`timescale 1ns/1ps
module synced_data_decoder_buffer_tb;
  localparam logic [6:0] F_DUP = 7'h01;
  localparam logic [6:0] F_PES = 7'h02;
  localparam logic [6:0] F_SEC = 7'h04;
  localparam logic [6:0] F_ISS = 7'h08;
  localparam logic [6:0] F_HDR = 7'h10;
  localparam logic [6:0] F_PTS = 7'h20;
  localparam logic [6:0] F_LST = 7'h40;
  typedef struct packed {
    logic [7:0] st;
    logic [7:0] enc;
    logic       ok;
  } row_s;
  row_s rows[10] = '{'{8'h06, 8'h02, 1'b1}, '{8'h06, 8'h05, 1'b1}, '{8'h06, 8'h07, 1'b1},
                     '{8'hC2, 8'h02, 1'b0}, '{8'h06, 8'h09, 1'b1}, '{8'h14, 8'h02, 1'b1},
                     '{8'h14, 8'h05, 1'b1}, '{8'h06, 8'h03, 1'b0}, '{8'h14, 8'h07, 1'b1},
                     '{8'h14, 8'h09, 1'b1}};
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  stream_type = 8'h06;
  logic [7:0]  encap_code = 8'h02;
  logic        streaming = 1'b1;
  logic        delay_valid = 1'b0;
  logic [32:0] delay_ticks = 33'h000000005;
  logic [32:0] stc_now = 33'h0FFFFFFFF;
  logic        out_ready = 1'b1;
  logic        sb_desc_present = 1'b1;
  logic        in_valid, in_ready, out_valid, out_unit_end, overflow_ff, underflow_ff;
  logic        seen_full, early;
  logic [7:0]  out_data;
  logic [63:0] in_rec;
  logic [7:0]  got_q[$], exp_q[$];
  int          units, checks, miscompares;

  always #4 clock = ~clock;

  stream_source i_stream_source (.clock, .rst_b, .in_valid, .in_ready, .in_rec);

  // Small elementary buffer and unit gap keep the fill and spacing cases short
  synced_data_decoder_buffer #(.DEB_BYTES(256), .MAX_UNITS(4), .AU_GAP(4))
    i_synced_data_decoder_buffer (
    .clock, .rst_b, .stream_type, .encap_code, .streaming, .profile(2'h0),
    .sb_desc_present, .smoothing_leak_rate(32'h000F4240), .delay_valid, .delay_ticks,
    .stc_now, .in_valid, .in_ready, .in_data(in_rec[7:0]), .in_dup(in_rec[8]),
    .in_pes_start(in_rec[9]), .in_sec_start(in_rec[10]), .in_is_section(in_rec[11]),
    .in_hdr(in_rec[12]), .in_pts_valid(in_rec[13]), .in_pts(in_rec[63:31]),
    .in_sec_num(in_rec[22:15]), .in_table_id(in_rec[30:23]), .in_last(in_rec[14]),
    .out_valid, .out_ready, .out_data, .out_unit_end, .overflow_ff, .underflow_ff);

  always @(posedge clock) begin
    if (rst_b && out_valid === 1'b1 && out_ready) begin
      got_q.push_back(out_data);
      if (out_unit_end === 1'b1) begin
        units++;
      end
    end
    if (rst_b && in_valid && in_ready === 1'b0) begin
      seen_full = 1'b1;
    end
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] d, input logic [6:0] f, input logic [7:0] tab,
                      input logic [32:0] pts, input logic keep);
    i_stream_source.pend_q.push_back({pts, tab, 8'h00, f, d});
    if (keep) begin
      exp_q.push_back(d);
    end
  endtask : send

  // Leak runs a byte a cycle; the margin lets the smoothing stage empty
  task automatic settle();
    for (int t = 0; t < 3000 && (i_stream_source.pend_q.size() > 0 || in_valid); t++) begin
      @(posedge clock);
    end
    repeat (40) @(posedge clock);
  endtask : settle

  task automatic finish_units(input int n);
    for (int t = 0; t < 4000 && got_q.size() < exp_q.size(); t++) begin
      @(posedge clock);
    end
    check(33'(units), 33'(n));
    check(33'(got_q.size()), 33'(exp_q.size()));
    foreach (exp_q[i]) begin
      check(33'(got_q[i]), 33'(exp_q[i]));
    end
    got_q.delete();
    exp_q.delete();
    units = 0;
  endtask : finish_units

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
  endtask : do_reset

  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[k]) begin
      @(posedge clock);
      stream_type <= rows[k].st;
      encap_code  <= rows[k].enc;
      @(posedge clock);
      send(8'hA0, F_PES | F_PTS | F_HDR, 8'h00, 33'(k + 1), 1'b0);
      for (int j = 0; j < 3; j++) begin
        send(8'(16 * k + j), 7'h00, 8'h00, 33'h0, rows[k].ok);
      end
      settle();
    end
    send(8'hA0, F_PES | F_PTS | F_HDR, 8'h00, 33'd20, 1'b0);
    finish_units(8);
    do_reset();
    out_ready <= 1'b0;
    seen_full = 1'b0;
    send(8'hA0, F_PES | F_PTS | F_HDR, 8'h00, 33'd1, 1'b0);
    for (int j = 0; j < 300; j++) begin
      if (j == 200) begin
        send(8'hA0, F_PES | F_PTS | F_HDR, 8'h00, 33'd2, 1'b0);
      end
      send(8'(j), 7'h00, 8'h00, 33'h0, 1'b1);
    end
    for (int t = 0; t < 1000 && !seen_full; t++) begin
      @(posedge clock);
    end
    check(seen_full, 1'b1);
    out_ready <= 1'b1;
    send(8'hA0, F_PES | F_PTS | F_HDR, 8'h00, 33'd3, 1'b0);
    finish_units(2);
    do_reset();
    streaming  <= 1'b0;
    encap_code <= 8'h05;
    @(posedge clock);
    send(8'h11, F_ISS | F_SEC | F_HDR, 8'h3B, 33'h0, 1'b0);
    send(8'h12, F_ISS, 8'h3B, 33'h0, 1'b0);
    send(8'h13, F_ISS | F_SEC | F_HDR | F_PTS, 8'h3C, 33'd10, 1'b0);
    send(8'h14, F_ISS | F_HDR | F_LST, 8'h3C, 33'h0, 1'b0);
    for (int j = 0; j < 6; j++) begin
      send(8'(32 + j), F_ISS, 8'h3C, 33'h0, 1'b0);
    end
    send(8'h31, F_ISS, 8'h3C, 33'h0, 1'b1);
    send(8'h32, F_ISS | F_DUP, 8'h3C, 33'h0, 1'b0);
    send(8'h33, F_ISS, 8'h3C, 33'h0, 1'b1);
    for (int j = 0; j < 4; j++) begin
      send(8'(64 + j), F_ISS | F_LST, 8'h3C, 33'h0, 1'b0);
    end
    send(8'h50, F_ISS | F_SEC | F_HDR | F_PTS, 8'h3C, 33'd11, 1'b0);
    finish_units(1);
    stc_now     <= 33'h0;
    delay_valid <= 1'b1;
    send(8'h61, F_ISS, 8'h3C, 33'h0, 1'b1);
    send(8'h70, F_ISS | F_SEC | F_HDR | F_PTS, 8'h3C, 33'd30, 1'b0);
    early = 1'b0;
    repeat (60) begin
      @(posedge clock);
      early |= out_valid;
    end
    check(early, 1'b0);
    stc_now <= 33'd6;
    finish_units(1);
    send(8'h71, F_ISS, 8'h3C, 33'h0, 1'b0);
    settle();
    stc_now <= 33'd40;
    for (int t = 0; t < 500 && underflow_ff !== 1'b1; t++) begin
      @(posedge clock);
    end
    check(underflow_ff, 1'b1);
    check(overflow_ff, 1'b0);
    print_verdict();
  end

  // About twenty times the expected run length
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule : synced_data_decoder_buffer_tb
